// >>> rtl/pnr_map.svh
// Purpose: register indices, field positions, reset values and mode codes
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef PNR_MAP_SVH
`define PNR_MAP_SVH

// register indices (byte address = index * 4)
`define PNR_IDX_PORT_CTRL   6'h20
`define PNR_IDX_MAN_DATA    6'h21
`define PNR_IDX_NEG_EN      6'h28
`define PNR_IDX_NEG_RESULT  6'h29
`define PNR_IDX_INT_STATUS  6'h2A
`define PNR_IDX_INT_MASK    6'h2B

// port control fields
`define PNR_PC_MANUAL_MODE  7
`define PNR_PC_NEG_ENABLE   6
`define PNR_PC_MANUAL_DIR   1
`define PNR_PC_MANUAL_OE    0

// negotiation enable fields
`define PNR_NE_RSVD_HI      7
`define PNR_NE_SLAVE_ID     6
`define PNR_NE_RSVD_LO      5
`define PNR_NE_EPP          4
`define PNR_NE_RLE          3
`define PNR_NE_ECP          2
`define PNR_NE_REV_BYTE     1
`define PNR_NE_REV_NIBBLE   0
`define PNR_NE_WMASK        8'h5F

// negotiation result fields
`define PNR_NR_OK           7
`define PNR_NR_FAILED       6
`define PNR_NR_TIMEOUT      5
`define PNR_NR_INVALID      4

// interrupt status / mask fields
`define PNR_IS_OK           0
`define PNR_IS_FAILED       1
`define PNR_IS_TIMEOUT      2
`define PNR_IS_INVALID      3

// reset values
`define PNR_RST_BYTE        8'h00
`define PNR_RST_NIB         4'h0

// protocol mode codes
`define PNR_CODE_NIBBLE     4'h0
`define PNR_CODE_BYTE       4'h1
`define PNR_CODE_COMPAT     4'h2
`define PNR_CODE_ECP        4'h3
`define PNR_CODE_ECP_RLE    4'h4
`define PNR_CODE_EPP        4'h5
`define PNR_CODE_SLAVE_ID   4'h6

`endif

// >>> rtl/pnr_pkg.sv
// Purpose: shared types of the parallel port negotiation register bank
// Assumes: constants live in pnr_map.svh
// Notes:   types only
package pnr_pkg;

	// negotiation engine states, one-hot
	typedef enum logic [1:0] {
		PNR_ST_IDLE = 2'b01,
		PNR_ST_EVAL = 2'b10
	} pnr_state_t;

endpackage : pnr_pkg

// >>> rtl/pnr_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: each bit is an independent level
// Notes:   only the second stage may be read outside
`timescale 1ns/1ps
module pnr_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// first stage feeds only the second one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule : pnr_sync

// >>> rtl/pnr_neg.sv
// Purpose: judges one negotiation request against the enables
// Assumes: request byte uses the negotiation enable bit layout
// Notes:   done is a one-cycle pulse with the outcome flags beside it
`timescale 1ns/1ps
`include "pnr_map.svh"
module pnr_neg (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       req_sync,
	input  wire logic [7:0] req_byte,
	input  wire logic       tmo_sync,
	input  wire logic [7:0] neg_en,
	input  wire logic       glob_en,
	output logic            done,
	output logic            ok,
	output logic            fail,
	output logic            tmo,
	output logic            inval,
	output logic [3:0]      code,
	output logic [3:0]      cur_code,
	output logic            ack
);
	pnr_pkg::pnr_state_t state_reg;
	logic                req_d_reg;
	logic                tmo_d_reg;
	logic [7:0]          byte_reg;
	logic                bad;
	logic                allow;
	logic [3:0]          want;

	// decode of the captured request byte
	always_comb begin
		bad   = byte_reg[`PNR_NE_RSVD_HI] | byte_reg[`PNR_NE_RSVD_LO]
			| ($countones({byte_reg[`PNR_NE_EPP], byte_reg[`PNR_NE_ECP],
			byte_reg[`PNR_NE_REV_BYTE], byte_reg[`PNR_NE_REV_NIBBLE]}) != 1)
			| (byte_reg[`PNR_NE_RLE] & !byte_reg[`PNR_NE_ECP]);
		allow = glob_en & (((byte_reg & `PNR_NE_WMASK) & ~neg_en) == `PNR_RST_BYTE)
			& !(byte_reg[`PNR_NE_SLAVE_ID] & byte_reg[`PNR_NE_EPP]);
		if (byte_reg[`PNR_NE_SLAVE_ID])
			want = `PNR_CODE_SLAVE_ID;
		else if (byte_reg[`PNR_NE_EPP])
			want = `PNR_CODE_EPP;
		else if (byte_reg[`PNR_NE_ECP])
			want = byte_reg[`PNR_NE_RLE] ? `PNR_CODE_ECP_RLE : `PNR_CODE_ECP;
		else if (byte_reg[`PNR_NE_REV_BYTE])
			want = `PNR_CODE_BYTE;
		else
			want = `PNR_CODE_NIBBLE;
	end

	// request capture, evaluation and outcome; a timeout always wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= pnr_pkg::PNR_ST_IDLE;
			{req_d_reg, tmo_d_reg, done, ok, fail, tmo, inval, ack} <= '0;
			byte_reg  <= `PNR_RST_BYTE;
			code      <= `PNR_CODE_COMPAT;
			cur_code  <= `PNR_CODE_COMPAT;
		end else begin
			req_d_reg <= req_sync;
			tmo_d_reg <= tmo_sync;
			{done, ok, fail, tmo, inval} <= '0;
			if (tmo_sync && !tmo_d_reg) begin
				{done, tmo} <= 2'b11;
				code      <= `PNR_CODE_COMPAT;
				cur_code  <= `PNR_CODE_COMPAT;
				ack       <= 1'b0;
				state_reg <= pnr_pkg::PNR_ST_IDLE;
			end else begin
				unique case (state_reg)
					pnr_pkg::PNR_ST_IDLE: begin
						if (req_sync && !req_d_reg) begin
							byte_reg  <= req_byte;
							state_reg <= pnr_pkg::PNR_ST_EVAL;
						end
					end
					pnr_pkg::PNR_ST_EVAL: begin
						done      <= 1'b1;
						state_reg <= pnr_pkg::PNR_ST_IDLE;
						if (bad) begin
							inval    <= 1'b1;
							code     <= `PNR_CODE_COMPAT;
							cur_code <= `PNR_CODE_COMPAT;
							ack      <= 1'b0;
						end else if (allow) begin
							ok       <= 1'b1;
							code     <= want;
							cur_code <= want;
							ack      <= 1'b1;
						end else begin
							fail     <= 1'b1;
							code     <= want;
							cur_code <= `PNR_CODE_COMPAT;
							ack      <= 1'b0;
						end
					end
				endcase
			end
		end
	end
endmodule : pnr_neg

// >>> rtl/pnr_top.sv
// Purpose: peripheral parallel port manual data and negotiation registers on APB
// Assumes: APB3 master, pclk 25 MHz, pins asynchronous to pclk
// Notes:   every access takes one wait state; registers sit at index * 4
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "pnr_map.svh"
module pnr_top #(
	parameter int ADDR_W = 8
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   irq,
	input  wire logic [7:0]        par_data_in,
	output logic      [7:0]        par_data_out,
	output logic                   par_data_oe,
	input  wire logic              host_neg_req,
	input  wire logic              host_timeout_in,
	output logic                   periph_neg_ack
);
	// synchronised pins
	logic [7:0] par_data_sync;
	logic [1:0] ctl_sync;

	// software visible state
	logic [7:0] port_control_reg;
	logic [7:0] manual_pin_data_reg;
	logic [7:0] neg_enable_reg;
	logic [3:0] neg_flags_reg;
	logic [3:0] neg_code_reg;
	logic [3:0] int_status_reg;
	logic [3:0] int_status_next;
	logic [3:0] int_mask_reg;

	// negotiation engine outcome
	logic       ev_done;
	logic       ev_ok;
	logic       ev_fail;
	logic       ev_tmo;
	logic       ev_inval;
	logic [3:0] ev_code;
	logic [3:0] ev_cur_code;
	logic [3:0] ev_vec;

	// bus decode
	logic       acc_phase;
	logic       acc_done;
	logic       wr_done;
	logic       rd_done;
	logic       hit_any;
	logic [7:0] rd_byte;
	logic       drive_ok;

	// true when the byte address selects the register at this index
	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [5:0] idx);
		reg_hit = (addr == ADDR_W'({idx, 2'b00}));
	endfunction : reg_hit

	// data lines and host handshakes pass two flops before any logic sees them
	pnr_sync #(
		.WIDTH(8)
	) u_data_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.async_in(par_data_in),
		.sync_out(par_data_sync)
	);

	pnr_sync #(
		.WIDTH(2)
	) u_ctl_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.async_in({host_timeout_in, host_neg_req}),
		.sync_out(ctl_sync)
	);

	// negotiation judge; the extensibility byte arrives on the data lines
	pnr_neg u_neg (
		.pclk    (pclk),
		.presetn (presetn),
		.req_sync(ctl_sync[0]),
		.req_byte(par_data_sync),
		.tmo_sync(ctl_sync[1]),
		.neg_en  (neg_enable_reg),
		.glob_en (port_control_reg[`PNR_PC_NEG_ENABLE]),
		.done    (ev_done),
		.ok      (ev_ok),
		.fail    (ev_fail),
		.tmo     (ev_tmo),
		.inval   (ev_inval),
		.code    (ev_code),
		.cur_code(ev_cur_code),
		.ack     (periph_neg_ack)
	);

	// APB phases: pready rises in the second access cycle, work is done on the next edge
	assign acc_phase = psel & penable;
	assign acc_done  = acc_phase & pready;
	assign wr_done   = acc_done & pwrite;
	assign rd_done   = acc_done & !pwrite;
	assign hit_any   = reg_hit(paddr, `PNR_IDX_PORT_CTRL) | reg_hit(paddr, `PNR_IDX_MAN_DATA)
		| reg_hit(paddr, `PNR_IDX_NEG_EN) | reg_hit(paddr, `PNR_IDX_NEG_RESULT)
		| reg_hit(paddr, `PNR_IDX_INT_STATUS) | reg_hit(paddr, `PNR_IDX_INT_MASK);

	// wait state generator; pslverr flags an unmapped address with pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= acc_phase & !pready;
			pslverr <= acc_phase & !pready & !hit_any;
		end
	end

	// read multiplexer, narrow registers sit in the low byte
	always_comb begin
		rd_byte = `PNR_RST_BYTE;
		if (reg_hit(paddr, `PNR_IDX_PORT_CTRL))
			rd_byte = port_control_reg;
		else if (reg_hit(paddr, `PNR_IDX_MAN_DATA))
			rd_byte = par_data_sync;
		else if (reg_hit(paddr, `PNR_IDX_NEG_EN))
			rd_byte = neg_enable_reg;
		else if (reg_hit(paddr, `PNR_IDX_NEG_RESULT))
			rd_byte = {neg_flags_reg, neg_code_reg};
		else if (reg_hit(paddr, `PNR_IDX_INT_STATUS))
			rd_byte = {4'h0, int_status_reg};
		else if (reg_hit(paddr, `PNR_IDX_INT_MASK))
			rd_byte = {4'h0, int_mask_reg};
	end

	// read data are captured together with pready and held for the completing edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (acc_phase && !pready && !pwrite)
			prdata <= {24'h00_0000, rd_byte};
		else if (acc_done)
			prdata <= 32'h0000_0000;
	end

	// port control: manual drive and global negotiation enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			port_control_reg <= `PNR_RST_BYTE;
		else if (wr_done && reg_hit(paddr, `PNR_IDX_PORT_CTRL))
			port_control_reg <= pwdata[7:0];
	end

	// manual data holds the last written byte; reads show the pins instead
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			manual_pin_data_reg <= `PNR_RST_BYTE;
		else if (wr_done && reg_hit(paddr, `PNR_IDX_MAN_DATA))
			manual_pin_data_reg <= pwdata[7:0];
	end

	// negotiation enables; bit 7 and bit 5 are held at zero by the write mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			neg_enable_reg <= `PNR_RST_BYTE;
		else if (wr_done && reg_hit(paddr, `PNR_IDX_NEG_EN))
			neg_enable_reg <= pwdata[7:0] & `PNR_NE_WMASK;
	end

	// all three manual controls must be set before the pins are driven
	assign drive_ok = port_control_reg[`PNR_PC_MANUAL_MODE]
		& port_control_reg[`PNR_PC_MANUAL_DIR]
		& port_control_reg[`PNR_PC_MANUAL_OE];

	// pin drivers registered so the outputs come from flops; one cycle behind the registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			par_data_out <= `PNR_RST_BYTE;
			par_data_oe  <= 1'b0;
		end else begin
			par_data_out <= manual_pin_data_reg;
			par_data_oe  <= drive_ok;
		end
	end

	// outcome flags: a new attempt replaces all four flags, so only the
	// latest outcome is shown; writing ones clears flags unless an attempt lands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			neg_flags_reg <= `PNR_RST_NIB;
		end else if (ev_done) begin
			neg_flags_reg <= {ev_ok, ev_fail, ev_tmo, ev_inval};
		end else if (wr_done && reg_hit(paddr, `PNR_IDX_NEG_RESULT)) begin
			neg_flags_reg <= neg_flags_reg & ~pwdata[7:4];
		end
	end

	// code field follows the engine; it shows the attempted mode after a failure
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			neg_code_reg <= `PNR_CODE_COMPAT;
		else if (ev_done)
			neg_code_reg <= ev_fail ? ev_code : ev_cur_code;
	end

	// event vector in interrupt bit order
	always_comb begin
		ev_vec = `PNR_RST_NIB;
		ev_vec[`PNR_IS_OK]      = ev_done & ev_ok;
		ev_vec[`PNR_IS_FAILED]  = ev_done & ev_fail;
		ev_vec[`PNR_IS_TIMEOUT] = ev_done & ev_tmo;
		ev_vec[`PNR_IS_INVALID] = ev_done & ev_inval;
	end

	// sticky status cleared by read; a new event in the read cycle survives
	always_comb begin
		int_status_next = int_status_reg;
		if (rd_done && reg_hit(paddr, `PNR_IDX_INT_STATUS))
			int_status_next = `PNR_RST_NIB;
		int_status_next = int_status_next | ev_vec;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			int_status_reg <= `PNR_RST_NIB;
		else
			int_status_reg <= int_status_next;
	end

	// interrupt mask, a one enables the matching status bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			int_mask_reg <= `PNR_RST_NIB;
		else if (wr_done && reg_hit(paddr, `PNR_IDX_INT_MASK))
			int_mask_reg <= pwdata[3:0];
	end

	// level interrupt from a flop fed by the next status, so it changes in the same cycle as the status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(int_status_next & int_mask_reg);
	end
endmodule : pnr_top

// >>> tb/pnr_host_model.sv
// Purpose: host side of the eight parallel data lines
// Assumes: no pull resistors on the data lines
// Notes:   released lines show the inverse of the last level
`timescale 1ns/1ps
module pnr_host_model (
	input  wire logic       pclk,
	input  wire logic [7:0] dev_out,
	input  wire logic       dev_oe,
	input  wire logic [7:0] host_val,
	input  wire logic       host_en,
	output logic      [7:0] pins
);
	logic [7:0] last_reg;

	// remember the wire so a floating line cannot echo a stale value
	always_ff @(posedge pclk) begin
		last_reg <= pins;
	end

	// device drive wins, then the host, else the line floats
	always_comb begin
		if (dev_oe)
			pins = dev_out;
		else if (host_en)
			pins = host_val;
		else
			pins = ~last_reg;
	end
endmodule : pnr_host_model

// >>> tb/pnr_chk.sv
// Purpose: concurrent checks on the register bank ports
// Assumes: written control values are shadowed from the bus
// Notes:   bound into pnr_top
`timescale 1ns/1ps
`include "pnr_map.svh"
module pnr_chk #(
	parameter int ADDR_W = 8
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [31:0]       prdata,
	input  wire logic              pready,
	input  wire logic              pslverr,
	input  wire logic [7:0]        par_data_out,
	input  wire logic              par_data_oe,
	input  wire logic              host_neg_req,
	input  wire logic              host_timeout_in,
	input  wire logic              periph_neg_ack
);
	localparam logic [7:0] A_PC = {`PNR_IDX_PORT_CTRL, 2'b00};
	localparam logic [7:0] A_MD = {`PNR_IDX_MAN_DATA, 2'b00};
	localparam logic [7:0] A_NE = {`PNR_IDX_NEG_EN, 2'b00};
	logic [7:0] pc_reg;
	logic [7:0] md_reg;
	logic [7:0] ne_reg;
	logic       hit;
	logic       pc_all;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// mapped addresses and the three manual drive bits
	assign hit = paddr[7:0] inside {A_PC, A_MD, A_NE, A_PC + 8'h24, A_PC + 8'h28, A_PC + 8'h2C};
	assign pc_all = pc_reg[7] && pc_reg[1] && pc_reg[0];

	// shadow of written values, taken at the completing edge only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_reg <= 8'h00;
			md_reg <= 8'h00;
			ne_reg <= 8'h00;
		end else if (psel && penable && pready && pwrite) begin
			if (paddr[7:0] == A_PC) pc_reg <= pwdata[7:0];
			if (paddr[7:0] == A_MD) md_reg <= pwdata[7:0];
			if (paddr[7:0] == A_NE) ne_reg <= pwdata[7:0];
		end
	end

	sequence acc_wait_s;
		psel && penable && !pready && !$past(penable);
	endsequence
	sequence acc_done_s;
		psel && penable && pready;
	endsequence

	pready_rise_a: assert property (acc_wait_s |=> pready)
		else $error("no answer one cycle into access");
	pready_pulse_a: assert property (acc_done_s |=> !pready)
		else $error("pready held past one cycle");
	slverr_map_a: assert property (pready |-> pslverr == !hit)
		else $error("pslverr wrong for address");
	rd_idle_a: assert property (!pready |-> prdata == 32'h00000000)
		else $error("read data not zero when idle");
	negen_rb_a: assert property (acc_done_s and (!pwrite && paddr[7:0] == A_NE)
		|-> prdata == {24'h000000, ne_reg & `PNR_NE_WMASK})
		else $error("enable register readback wrong");
	oe_gate_a: assert property (pc_all == $past(pc_all) && pc_all == $past(pc_all, 2)
		|-> par_data_oe == pc_all)
		else $error("drive enable does not follow control bits");
	drive_val_a: assert property (par_data_oe && md_reg == $past(md_reg)
		&& md_reg == $past(md_reg, 2) |-> par_data_out == md_reg)
		else $error("driven data differs from written data");
	tmo_ack_a: assert property ($rose(host_timeout_in) && !host_neg_req
		|-> ##[3:8] !periph_neg_ack)
		else $error("ack kept after host timeout");
endmodule : pnr_chk

bind pnr_top pnr_chk #(.ADDR_W(ADDR_W)) pnr_chk_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.par_data_out(par_data_out), .par_data_oe(par_data_oe), .host_neg_req(host_neg_req),
	.host_timeout_in(host_timeout_in), .periph_neg_ack(periph_neg_ack)
);

// >>> tb/tb_p1284_manual_data_and_negotiation_regs.sv
// Purpose: self-checking bench for the negotiation register bank
// Assumes: APB master with one idle cycle between transfers
// Notes:   expected results come from an integer model below
`timescale 1ns/1ps
`include "pnr_map.svh"
module tb_p1284_manual_data_and_negotiation_regs;
	localparam logic [7:0] A_PC = {`PNR_IDX_PORT_CTRL, 2'b00};
	localparam logic [7:0] A_MD = {`PNR_IDX_MAN_DATA, 2'b00};
	localparam logic [7:0] A_NE = {`PNR_IDX_NEG_EN, 2'b00};
	localparam logic [7:0] A_RS = {`PNR_IDX_NEG_RESULT, 2'b00};
	localparam logic [7:0] A_IS = {`PNR_IDX_INT_STATUS, 2'b00};
	localparam logic [7:0] A_IM = {`PNR_IDX_INT_MASK, 2'b00};
	logic        pclk            = 1'b0;
	logic        presetn         = 1'b0;
	logic        psel            = 1'b0;
	logic        penable         = 1'b0;
	logic        pwrite          = 1'b0;
	logic [7:0]  paddr           = 8'h00;
	logic [31:0] pwdata          = 32'h00000000;
	logic [7:0]  host_val        = 8'h00;
	logic        host_en         = 1'b1;
	logic        host_neg_req    = 1'b0;
	logic        host_timeout_in = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [7:0]  pins;
	logic [7:0]  par_data_out;
	logic        par_data_oe;
	logic        periph_neg_ack;
	logic [31:0] q;
	logic [7:0]  md;
	logic [7:0]  r;
	logic [7:0]  en;
	logic [7:0]  modes [5] = '{8'h01, 8'h02, 8'h04, 8'h0C, 8'h10};
	logic [7:0]  bad [4]   = '{8'h03, 8'h08, 8'h20, 8'h00};
	int          seed;
	int          miscompares = 0;
	int          checks_done = 0;

	always #20 pclk = ~pclk;

	pnr_top #(.ADDR_W(8)) pnr_top_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .par_data_in(pins), .par_data_out(par_data_out),
		.par_data_oe(par_data_oe), .host_neg_req(host_neg_req),
		.host_timeout_in(host_timeout_in), .periph_neg_ack(periph_neg_ack)
	);

	pnr_host_model pnr_host_model_i (
		.pclk(pclk), .dev_out(par_data_out), .dev_oe(par_data_oe),
		.host_val(host_val), .host_en(host_en), .pins(pins)
	);

	// outcome byte of one attempt: flags in 7:4, mode code in 3:0
	function automatic int exp_res(input int rq, input int e, input int g);
		int m;
		int c;
		m = rq & 8'h17;
		if ((rq & 8'hA0) != 0 || !(m inside {1, 2, 4, 16}) || ((rq & 8) != 0 && (rq & 4) == 0))
			return 8'h12;
		c = (m == 1) ? 0 : (m == 2) ? 1 : (m == 16) ? 5 : ((rq & 8) != 0) ? 4 : 3;
		if (g != 0 && (rq & ~e & 8'h5F) == 0 && (rq & 8'h50) != 8'h50)
			return 8'h80 | c;
		return 8'h40 | c;
	endfunction : exp_res

	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask : wt

	// one transfer; entered just after a rising edge, leaves one idle cycle
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) miscompares++;
		q = prdata;
		check(32'(pslverr), 32'(!(a inside {A_PC, A_MD, A_NE, A_RS, A_IS, A_IM})));
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		check(q, e);
	endtask : rd

	// the byte settles on the lines before the request edge
	task automatic neg(input logic [7:0] b);
		host_val <= b;
		wt(3);
		host_neg_req <= 1'b1;
		wt(8);
		host_neg_req <= 1'b0;
		wt(3);
	endtask : neg

	// a hang ends the run with a mismatch
	initial begin
		#(40 * 8000);
		miscompares++;
		results();
	end

	initial begin
		seed = 32'hb1db28ef;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(A_PC, 32'h00000000);
		rd(A_NE, 32'h00000000);
		rd(A_RS, 32'h00000002);
		rd(A_IM, 32'h00000000);
		rd(8'h04, 32'h00000000);
		wr(A_NE, 32'h000000DF);
		rd(A_NE, 32'h0000005F);
		// every combination of the three manual drive bits
		for (int i = 0; i < 8; i++) begin
			md = $random(seed);
			host_val <= $random(seed);
			wr(A_MD, 32'(md));
			wr(A_PC, 32'({i[2], 5'h00, i[1:0]}));
			wt(4);
			check(32'(par_data_oe), 32'(i == 7));
			if (i == 7) check(32'(par_data_out), 32'(md));
			rd(A_MD, 32'((i == 7) ? md : host_val));
		end
		// each mode: enabled, not enabled, global enable off
		for (int k = 0; k < 15; k++) begin
			r  = modes[k % 5];
			en = (k >= 5 && k < 10) ? (8'h5F & ~r) : 8'h5F;
			wr(A_PC, (k < 10) ? 32'h00000040 : 32'h00000000);
			wr(A_NE, 32'(en));
			neg(r);
			rd(A_RS, 32'(exp_res(r, en, k < 10)));
			check(32'(periph_neg_ack), 32'(exp_res(r, en, k < 10) >> 7));
		end
		wr(A_PC, 32'h00000040);
		for (int k = 0; k < 4; k++) begin
			neg(bad[k]);
			rd(A_RS, 32'h00000012);
			check(32'(periph_neg_ack), 32'h00000000);
		end
		neg(8'h50);
		apb(1'b0, A_RS, 32'h00000000);
		check(q & 32'h000000F0, 32'h00000040);
		apb(1'b0, A_IS, 32'h00000000);
		wr(A_IM, 32'h00000004);
		neg(8'h02);
		rd(A_RS, 32'h00000081);
		check(32'(irq), 32'h00000000);
		wr(A_RS, 32'h000000F0);
		rd(A_RS, 32'h00000001);
		host_timeout_in <= 1'b1;
		wt(8);
		host_timeout_in <= 1'b0;
		wt(3);
		rd(A_RS, 32'h00000022);
		check(32'(periph_neg_ack), 32'h00000000);
		check(32'(irq), 32'h00000001);
		rd(A_IS, 32'h00000005);
		wt(2);
		check(32'(irq), 32'h00000000);
		results();
	end
endmodule : tb_p1284_manual_data_and_negotiation_regs
